// [core/rbcfs_pkg.sv]
// Package: constants and types of the remote base controller fallback block.
// Assumes: used by rbcfs_top and rbcfs_baud_decode, no imports.
package rbcfs_pkg;

  localparam int unsigned BAUD_CODE_W = 3;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned SW_W        = 10;
  localparam int unsigned BAUD_W      = 16;

  // Switch positions within the 10-bit dipswitch word; bit 0 is switch 1
  localparam int unsigned SW_BAUD_LO  = 0;
  localparam int unsigned SW_ADDR_LO  = 3;

  localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7d;

  localparam logic [BAUD_CODE_W-1:0] CODE_38400 = 3'h1;
  localparam logic [BAUD_CODE_W-1:0] CODE_19200 = 3'h7;
  localparam logic [BAUD_CODE_W-1:0] CODE_9600  = 3'h6;
  localparam logic [BAUD_CODE_W-1:0] CODE_2400  = 3'h4;
  localparam logic [BAUD_CODE_W-1:0] CODE_1200  = 3'h2;
  localparam logic [BAUD_CODE_W-1:0] CODE_300   = 3'h0;

  localparam logic [BAUD_W-1:0] BAUD_38400 = 16'h9600;
  localparam logic [BAUD_W-1:0] BAUD_19200 = 16'h4b00;
  localparam logic [BAUD_W-1:0] BAUD_9600  = 16'h2580;
  localparam logic [BAUD_W-1:0] BAUD_2400  = 16'h0960;
  localparam logic [BAUD_W-1:0] BAUD_1200  = 16'h04b0;
  localparam logic [BAUD_W-1:0] BAUD_300   = 16'h012c;

  // Status display codes
  localparam logic [3:0] DISP_GOOD     = 4'h0;
  localparam logic [3:0] DISP_TIMEOUT  = 4'h3;
  localparam logic [3:0] DISP_CFG_ERR  = 4'he;
  localparam logic [3:0] DISP_WATCHDOG = 4'h8;

  // Module zero/hold choice per analog/word channel
  typedef enum logic [1:0] {
    RBCFS_SEL_NONE,
    RBCFS_SEL_ZERO,
    RBCFS_SEL_HOLD
  } rbcfs_sel_e;

endpackage

// [core/rbcfs_baud_decode.sv]
// Baud code decoder: switches 1..3 to a baud rate and an invalid flag.
// Assumes: code is a latched, stable value.
`timescale 1ns/10ps
module rbcfs_baud_decode (
  input  wire logic [rbcfs_pkg::BAUD_CODE_W-1:0] code,
  output logic      [rbcfs_pkg::BAUD_W-1:0]      baud,
  output logic                                   invalid
);

  always_comb begin
    invalid = 1'b0;
    unique case (code)
      rbcfs_pkg::CODE_38400: baud = rbcfs_pkg::BAUD_38400;
      rbcfs_pkg::CODE_19200: baud = rbcfs_pkg::BAUD_19200;
      rbcfs_pkg::CODE_9600:  baud = rbcfs_pkg::BAUD_9600;
      rbcfs_pkg::CODE_2400:  baud = rbcfs_pkg::BAUD_2400;
      rbcfs_pkg::CODE_1200:  baud = rbcfs_pkg::BAUD_1200;
      rbcfs_pkg::CODE_300:   baud = rbcfs_pkg::BAUD_300;
      default: begin
        // Two codes left over; fall back to a common safe rate
        baud    = rbcfs_pkg::BAUD_9600;
        invalid = 1'b1;
      end
    endcase
  end

endmodule // rbcfs_baud_decode

// [core/rbcfs_top.sv]
// Remote base controller: output fallback, switch latching, status.
// Assumes: inputs synchronous to mclk; rst is power-up reset.
//
// Operation
// - Comm loss: discrete outputs per jumper
// - Off jumper: zero only Zero-selected analogs
// - Freeze jumper: all analogs hold
// - Hold selection overrides Off jumper
// - No jumper fitted reports error
// - Watchdog: ignore jumper, discretes zero
// - Switches 1-3 decode baud rate
// - Codes 011, 101: error, 9600 baud
// - Baud switches latched at reset only
// - Serial port disabled until enabled
// - Address from switches 4-10, 10 LSB
// - Addresses 0 to 125 valid
// - Address switches latched at reset only
// - Reset button drops off fieldbus
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module rbcfs_top #(
  parameter int unsigned N_DISC = 16,
  parameter int unsigned N_WORD = 4,
  parameter int unsigned WORD_W = 16
) (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          reset_button,
  input  wire logic [rbcfs_pkg::SW_W-1:0]    dipswitch,
  input  wire logic                          fallback_off,
  input  wire logic                          fallback_freeze,
  input  wire logic                          watchdog_expired,
  input  wire logic                          comm_ok,
  input  wire logic                          cfg_serial_enable,
  input  wire logic                          cfg_valid,
  input  wire logic [N_DISC-1:0]             disc_in,
  input  wire logic [N_WORD*WORD_W-1:0]      word_in,
  input  wire logic [N_WORD*2-1:0]           word_sel,
  input  wire logic                          status_clr_we,
  input  wire logic [3:0]                    status_clr,
  input  wire logic                          mask_we,
  input  wire logic [3:0]                    mask_wdata,
  output logic      [N_DISC-1:0]             disc_out,
  output logic      [N_WORD*WORD_W-1:0]      word_out,
  output logic      [rbcfs_pkg::ADDR_W-1:0]  station_addr,
  output logic      [rbcfs_pkg::BAUD_W-1:0]  serial_baud,
  output logic                               serial_enable,
  output logic                               bus_join,
  output logic      [3:0]                    status_display,
  output logic      [3:0]                    irq_status,
  output logic      [3:0]                    irq_mask,
  output logic                               irq
);

  ////////////////////////////////////////////////////////////////////////
  // Switch latching: only at power-up reset or button press

  logic                                 latch_pending;
  logic                                 next_latch_pending;
  logic [rbcfs_pkg::BAUD_CODE_W-1:0]    baud_code;
  logic [rbcfs_pkg::BAUD_CODE_W-1:0]    next_baud_code;
  logic [rbcfs_pkg::ADDR_W-1:0]         next_station_addr;
  logic                                 ser_en;
  logic                                 next_ser_en;
  logic [rbcfs_pkg::ADDR_W-1:0]         addr_sw;
  logic                                 baud_invalid;
  logic [rbcfs_pkg::BAUD_W-1:0]         baud_dec;

  // Switch 4 is the MSB, switch 10 the LSB
  always_comb begin
    for (int i = 0; i < rbcfs_pkg::ADDR_W; i++) begin
      addr_sw[i] = dipswitch[rbcfs_pkg::SW_ADDR_LO + rbcfs_pkg::ADDR_W - 1 - i];
    end
  end

  always_comb begin
    next_latch_pending = 1'b0;
    next_baud_code     = baud_code;
    next_station_addr  = station_addr;
    next_ser_en        = ser_en;
    if (reset_button) begin
      // Button acts as a warm reset: re-read switches next cycle
      next_latch_pending = 1'b1;
      next_ser_en        = 1'b0;
    end else if (latch_pending) begin
      // Switch 1 is code MSB
      next_baud_code    = {dipswitch[rbcfs_pkg::SW_BAUD_LO],
                           dipswitch[rbcfs_pkg::SW_BAUD_LO + 1],
                           dipswitch[rbcfs_pkg::SW_BAUD_LO + 2]};
      next_station_addr = addr_sw;
    end else if (cfg_valid) begin
      next_ser_en = cfg_serial_enable;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      latch_pending <= 1'b1;
      baud_code     <= rbcfs_pkg::CODE_9600;
      station_addr  <= '0;
      ser_en        <= 1'b0;
    end else begin
      latch_pending <= next_latch_pending;
      baud_code     <= next_baud_code;
      station_addr  <= next_station_addr;
      ser_en        <= next_ser_en;
    end
  end

  rbcfs_baud_decode u_baud (
    .code    (baud_code),
    .baud    (baud_dec),
    .invalid (baud_invalid)
  );

  ////////////////////////////////////////////////////////////////////////
  // Configuration checks and fieldbus participation

  logic addr_invalid;
  logic jumper_missing;
  logic cfg_error;
  logic online;
  logic next_online;

  assign addr_invalid   = station_addr > rbcfs_pkg::ADDR_MAX;
  // Both or neither position fitted is not a usable selection
  assign jumper_missing = fallback_off == fallback_freeze;
  assign cfg_error      = baud_invalid | jumper_missing | addr_invalid;

  always_comb begin
    next_online = online;
    if (reset_button || latch_pending || addr_invalid || watchdog_expired) begin
      next_online = 1'b0;
    end else begin
      next_online = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      online <= 1'b0;
    end else begin
      online <= next_online;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output fallback

  logic                     comm_lost;
  logic [N_DISC-1:0]        next_disc_out;
  logic [N_WORD*WORD_W-1:0] next_word_out;

  // Off-bus or button reset counts as lost communication
  assign comm_lost = ~comm_ok | ~online;

  always_comb begin
    next_disc_out = disc_in;
    if (watchdog_expired) begin
      next_disc_out = '0;
    end else if (comm_lost) begin
      // Missing jumper treated as Freeze: least disruptive choice
      next_disc_out = fallback_off && !fallback_freeze ? '0 : disc_out;
    end
  end

  generate
    for (genvar g = 0; g < N_WORD; g++) begin : g_word
      rbcfs_pkg::rbcfs_sel_e sel;
      assign sel = rbcfs_pkg::rbcfs_sel_e'(word_sel[g*2 +: 2]);
      always_comb begin
        next_word_out[g*WORD_W +: WORD_W] = word_in[g*WORD_W +: WORD_W];
        if (watchdog_expired) begin
          // Module choice alone decides; none means hold
          next_word_out[g*WORD_W +: WORD_W] = (sel == rbcfs_pkg::RBCFS_SEL_ZERO) ?
            '0 : word_out[g*WORD_W +: WORD_W];
        end else if (comm_lost) begin
          if (fallback_off && !fallback_freeze &&
              sel == rbcfs_pkg::RBCFS_SEL_ZERO) begin
            next_word_out[g*WORD_W +: WORD_W] = '0;
          end else begin
            // Freeze, Hold or no selection keeps the last value
            next_word_out[g*WORD_W +: WORD_W] = word_out[g*WORD_W +: WORD_W];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      disc_out <= '0;
      word_out <= '0;
    end else begin
      disc_out <= next_disc_out;
      word_out <= next_word_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status display, serial port, interrupts
  // Bits: 0 comm lost, 1 config error, 2 watchdog, 3 address invalid

  logic [3:0] next_display;
  logic [3:0] events;
  logic [3:0] next_irq_status;
  logic [3:0] next_irq_mask;
  logic [rbcfs_pkg::BAUD_W-1:0] next_baud;
  logic       next_serial_enable;
  logic       next_bus_join;

  assign events = {addr_invalid, watchdog_expired, cfg_error, comm_lost};

  always_comb begin
    if (watchdog_expired) begin
      next_display = rbcfs_pkg::DISP_WATCHDOG;
    end else if (cfg_error) begin
      next_display = rbcfs_pkg::DISP_CFG_ERR;
    end else if (comm_lost) begin
      next_display = rbcfs_pkg::DISP_TIMEOUT;
    end else begin
      next_display = rbcfs_pkg::DISP_GOOD;
    end
    next_baud          = baud_dec;
    next_serial_enable = ser_en;
    next_bus_join      = online;
    // Set wins over a simultaneous write-one clear
    next_irq_status = (irq_status & ~(status_clr_we ? status_clr : 4'h0)) | events;
    next_irq_mask   = mask_we ? mask_wdata : irq_mask;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      status_display <= rbcfs_pkg::DISP_GOOD;
      serial_baud    <= rbcfs_pkg::BAUD_9600;
      serial_enable  <= 1'b0;
      bus_join       <= 1'b0;
      irq_status     <= 4'h0;
      irq_mask       <= 4'h0;
    end else begin
      status_display <= next_display;
      serial_baud    <= next_baud;
      serial_enable  <= next_serial_enable;
      bus_join       <= next_bus_join;
      irq_status     <= next_irq_status;
      irq_mask       <= next_irq_mask;
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule // rbcfs_top

// [verif/rbcfs_checker.sv]
// Checker: fallback, latch and join relations at the top ports.
// Assumes: bound into rbcfs_top; one mclk domain.
`timescale 1ns/10ps
module rbcfs_checker #(
  parameter int unsigned N_DISC = 16,
  parameter int unsigned N_WORD = 4,
  parameter int unsigned WORD_W = 16
) (
  input wire logic                         mclk,
  input wire logic                         rst,
  input wire logic                         reset_button,
  input wire logic                         fallback_off,
  input wire logic                         fallback_freeze,
  input wire logic                         watchdog_expired,
  input wire logic                         comm_ok,
  input wire logic [N_WORD*2-1:0]          word_sel,
  input wire logic [N_DISC-1:0]            disc_out,
  input wire logic [N_WORD*WORD_W-1:0]     word_out,
  input wire logic [rbcfs_pkg::ADDR_W-1:0] station_addr,
  input wire logic [rbcfs_pkg::BAUD_W-1:0] serial_baud,
  input wire logic                         serial_enable,
  input wire logic                         bus_join,
  input wire logic [3:0]                   irq_status
);
  // Cycles since last reset or button; switches may move only early
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  always_comb next_quiet = (rst || reset_button) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
  always_ff @(posedge mclk) quiet <= next_quiet;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic off_only;
  assign off_only = fallback_off && !fallback_freeze;
  property p_off_disc; !comm_ok && off_only |=> disc_out == '0; endproperty
  a_off_disc: assert property (p_off_disc) else $error("discrete not zeroed");
  property p_frz; !comm_ok && fallback_freeze && !fallback_off && !watchdog_expired
    |=> $stable(disc_out) && $stable(word_out); endproperty
  a_frz: assert property (p_frz) else $error("freeze did not hold");
  property p_zero; !comm_ok && off_only && !watchdog_expired && word_sel[1:0] == 2'h1
    |=> word_out[WORD_W-1:0] == '0; endproperty
  a_zero: assert property (p_zero) else $error("zero channel not zeroed");
  property p_hold; (!comm_ok || watchdog_expired) && word_sel[1:0] == 2'h2
    |=> $stable(word_out[WORD_W-1:0]); endproperty
  a_hold: assert property (p_hold) else $error("hold channel moved");
  property p_nojmp; fallback_off == fallback_freeze |-> ##[1:2] irq_status[1]; endproperty
  a_nojmp: assert property (p_nojmp) else $error("jumper error missing");
  property p_wdog; watchdog_expired |=> disc_out == '0; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog discretes");
  property p_latch; quiet > 4'h6 |-> $stable(station_addr) && $stable(serial_baud); endproperty
  a_latch: assert property (p_latch) else $error("switch moved late");
  property p_ser; $fell(rst) |-> !serial_enable; endproperty
  a_ser: assert property (p_ser) else $error("serial up at reset");
  // Join and enable are registered behind their state flops: two cycles of lag
  property p_btn; reset_button |-> ##2 (!bus_join && !serial_enable); endproperty
  a_btn: assert property (p_btn) else $error("still on bus");
  property p_badaddr; quiet > 4'h6 && station_addr > rbcfs_pkg::ADDR_MAX |-> !bus_join;
  endproperty
  a_badaddr: assert property (p_badaddr) else $error("joined bad address");
endmodule // rbcfs_checker
bind rbcfs_top rbcfs_checker #(.N_DISC(N_DISC), .N_WORD(N_WORD), .WORD_W(WORD_W)) chk_inst (
  .mclk(mclk), .rst(rst), .reset_button(reset_button), .fallback_off(fallback_off),
  .fallback_freeze(fallback_freeze), .watchdog_expired(watchdog_expired), .comm_ok(comm_ok),
  .word_sel(word_sel), .disc_out(disc_out), .word_out(word_out), .station_addr(station_addr),
  .serial_baud(serial_baud), .serial_enable(serial_enable), .bus_join(bus_join),
  .irq_status(irq_status));

// [verif/rbcfs_master.sv]
// Fieldbus master model: live images, link state, config pulse.
// Assumes: tasks called from the bench, each starts at a rising edge.
`timescale 1ns/10ps
module rbcfs_master (
  input  wire logic        mclk,
  output logic             comm_ok,
  output logic             cfg_serial_enable,
  output logic             cfg_valid,
  output logic [15:0]      disc_in,
  output logic [63:0]      word_in
);
  initial begin
    comm_ok = 1'b1;
    cfg_serial_enable = 1'b0;
    cfg_valid = 1'b0;
    disc_in = 16'h0000;
    word_in = 64'h0;
  end
  // New image every cycle, so a stale output can never match by luck
  task automatic step(input logic up);
    @(posedge mclk);
    comm_ok <= up;
    disc_in <= 16'($urandom);
    word_in <= {$urandom, $urandom};
  endtask
  task automatic configure(input logic en);
    @(posedge mclk);
    cfg_serial_enable <= en;
    cfg_valid <= 1'b1;
    @(posedge mclk);
    cfg_valid <= 1'b0;
  endtask
endmodule // rbcfs_master

// [verif/rbcfs_top_tb.sv]
// Testbench: switch latching, fallback table, interrupts.
// Assumes: default top parameters, 4 channels of 16 bits.
`timescale 1ns/10ps
module rbcfs_top_tb;
  localparam int BAUDS [8] = '{300, 38400, 1200, 9600, 2400, 9600, 9600, 19200};
  logic mclk = 1'b0, rst = 1'b1, reset_button = 1'b0, fallback_off = 1'b1;
  logic fallback_freeze = 1'b0, watchdog_expired = 1'b0, status_clr_we = 1'b0, mask_we = 1'b0;
  logic [9:0] dipswitch = 10'h000;
  logic [7:0] word_sel = 8'h00;
  logic [3:0] status_clr = 4'h0, mask_wdata = 4'h0;
  logic comm_ok, cfg_serial_enable, cfg_valid, serial_enable, bus_join, irq;
  logic [15:0] disc_in, disc_out, serial_baud;
  logic [63:0] word_in, word_out;
  logic [6:0] station_addr;
  logic [3:0] status_display, irq_status, irq_mask;
  int num_errors = 0, compares = 0;
  always #50 mclk = ~mclk;
  rbcfs_master m (.mclk(mclk), .comm_ok(comm_ok), .cfg_serial_enable(cfg_serial_enable),
    .cfg_valid(cfg_valid), .disc_in(disc_in), .word_in(word_in));
  rbcfs_top rbcfs_top_inst (.mclk(mclk), .rst(rst), .reset_button(reset_button),
    .dipswitch(dipswitch), .fallback_off(fallback_off), .fallback_freeze(fallback_freeze),
    .watchdog_expired(watchdog_expired), .comm_ok(comm_ok), .cfg_serial_enable(cfg_serial_enable),
    .cfg_valid(cfg_valid), .disc_in(disc_in), .word_in(word_in), .word_sel(word_sel),
    .status_clr_we(status_clr_we), .status_clr(status_clr), .mask_we(mask_we),
    .mask_wdata(mask_wdata), .disc_out(disc_out), .word_out(word_out),
    .station_addr(station_addr), .serial_baud(serial_baud), .serial_enable(serial_enable),
    .bus_join(bus_join), .status_display(status_display), .irq_status(irq_status),
    .irq_mask(irq_mask), .irq(irq));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Press the button with new switches; code is {sw1,sw2,sw3}, sw10 is address LSB
  task automatic latch(input int c, input int a);
    @(posedge mclk);
    for (int i = 0; i < 3; i++) dipswitch[i] <= c[2-i];
    for (int i = 0; i < 7; i++) dipswitch[3+i] <= a[6-i];
    reset_button <= 1'b1;
    repeat (2) @(posedge mclk);
    reset_button <= 1'b0;
    @(negedge mclk) check(bus_join, 0);
    repeat (8) @(posedge mclk);
    dipswitch <= 10'($urandom);
    repeat (10) @(negedge mclk);
    check(serial_baud, BAUDS[c]);
    check(station_addr, a);
    check(bus_join, a <= 125);
    if (a > 125) check(irq_status[3], 1);
    if (a > 125) check(status_display, rbcfs_pkg::DISP_CFG_ERR);
  endtask
  task automatic fall(input logic off, input logic frz, input logic wd);
    logic [15:0] dl;
    logic [63:0] wl, we;
    logic [7:0] sel;
    logic zap;
    sel = 8'($urandom);
    zap = wd || (off && !frz);
    m.step(1'b1);
    word_sel <= sel;
    fallback_off <= off;
    fallback_freeze <= frz;
    m.step(1'b1);
    @(negedge mclk);
    dl = disc_in;
    wl = word_in;
    we = wl;
    for (int g = 0; g < 4; g++) if (zap && sel[2*g+:2] == 2'h1) we[16*g+:16] = 16'h0000;
    m.step(wd);
    watchdog_expired <= wd;
    @(negedge mclk) check(disc_out, dl);
    repeat (3) m.step(wd);
    @(negedge mclk);
    check(disc_out, zap ? 16'h0000 : dl);
    check(word_out, we);
    if (off == frz) check(irq_status[1], 1);
    if (wd) check(irq_status[2], 1);
    check(status_display, wd ? rbcfs_pkg::DISP_WATCHDOG : off == frz ? rbcfs_pkg::DISP_CFG_ERR :
      rbcfs_pkg::DISP_TIMEOUT);
    $display("fallback %0d%0d%0d done", off, frz, wd);
  endtask
  task automatic restore();
    m.step(1'b1);
    watchdog_expired <= 1'b0;
    fallback_off <= 1'b1;
    fallback_freeze <= 1'b0;
    latch(6, 9);
  endtask
  task automatic wr(input logic clr, input logic [3:0] d);
    @(posedge mclk);
    status_clr_we <= clr;
    mask_we <= !clr;
    status_clr <= d;
    mask_wdata <= d;
    @(posedge mclk);
    status_clr_we <= 1'b0;
    mask_we <= 1'b0;
    @(negedge mclk);
  endtask
  initial begin
    #2000000;
    num_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hf246));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    latch(6, 20);
    check(serial_enable, 0);
    m.configure(1'b1);
    repeat (3) @(negedge mclk);
    check(serial_enable, 1);
    for (int c = 0; c < 8; c++) latch(c, c == 3 ? 126 : c == 7 ? 127 : c == 5 ? 125 : $urandom_range(125));
    latch(5, 0);
    check(status_display, rbcfs_pkg::DISP_CFG_ERR);
    $display("switch tests done");
    for (int k = 0; k < 8; k++) begin
      fall(k[0], k[1], k[2]);
      restore();
    end
    fall(1'b1, 1'b0, 1'b0);
    wr(1'b0, 4'h0);
    check(irq, 0);
    wr(1'b0, 4'h1);
    check(irq_mask, 4'h1);
    check(irq_status[0], 1);
    check(irq, 1);
    restore();
    wr(1'b1, 4'hf);
    check(irq_status, 4'h0);
    check(irq, 0);
    check(status_display, rbcfs_pkg::DISP_GOOD);
    $display("irq test done");
    end_sim();
  end
endmodule // rbcfs_top_tb
